// [rtl/gcc_global_regs.sv]
`timescale 1ns/1ps
// How it works
// - Unit power register resets FFh; zero bit powers down its unit
// - Serial power register resets F0h; bits 7..4 power serial F..C
// - Writing one to serial register bit 0 sleeps the whole chip
// - Option bit 6 defaults one for 48 MHz clock, zero 24 MHz
// - Option bit 4 selects system fan push-pull, else open-drain
// - Option bit 3 selects processor fan push-pull, else open-drain
// - Option bit 2 read-only, loaded from keyboard controller strap
// - Option bit 1 writable, strap-initialised, one disables floppy interface
// - Floppy disabled puts serial F and GPIO on shared pins
// - Tri-state register resets zero; bits float serial B, A, parallel, floppy
// - Strap bit 6 selects config port 2E or 4E for key
// - Lock bit 5 set blocks configuration register access
// - Legacy bit 3 clear lets floppy output reg bit 3 gate interrupt
// - Legacy bit 2 clear lets parallel control bit 4 gate interrupt
// - Legacy bit 1 clear lets serial A handshake bit 3 gate interrupt
// - Legacy bit 0 clear lets serial B handshake bit 3 gate interrupt
module gcc_global_regs
   import gcc_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   // Power-on straps, sampled on first clock after reset release
   input  wire logic       strap_kbc_en,
   input  wire logic       strap_fdc_dis,
   input  wire logic       strap_port_sel,
   // Configuration index/data port
   input  wire logic       cfg_wr,
   input  wire logic       cfg_rd,
   input  wire logic [7:0] cfg_index,
   input  wire logic [7:0] cfg_wdata,
   output logic      [7:0] cfg_rdata,
   output logic            cfg_rvalid,
   // Unit controls
   output logic            hardware_monitor_pwr,
   output logic            serial_b_pwr,
   output logic            serial_a_pwr,
   output logic            parallel_port_pwr,
   output logic            floppy_disk_controller_pwr,
   output logic      [3:0] serial_fc_pwr,
   output logic            immediate_chip_sleep,
   output logic            input_clock_rate_select,
   output logic            system_fan_output_pp,
   output logic            processor_fan_output_pp,
   output logic            keyboard_controller_en,
   output logic            floppy_pins_serial_f,
   output logic            serial_b_float,
   output logic            serial_a_float,
   output logic            parallel_float,
   output logic            floppy_float,
   output logic      [7:0] config_port_addr,
   output logic            config_lock,
   // Legacy interrupt gate inputs from units
   input  wire logic       floppy_dor_bit3,
   input  wire logic       parallel_control_reg_bit4,
   input  wire logic       serial_a_handshake_control_reg_bit3,
   input  wire logic       serial_b_handshake_control_reg_bit3,
   // Legacy interrupt enables to units
   output logic            floppy_irq_en,
   output logic            parallel_irq_en,
   output logic            serial_a_irq_en,
   output logic            serial_b_irq_en
);

   ////////////////////////////////////////////////////////////////////////////
   // Register bank
   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic {GCC_ST_STRAP, GCC_ST_RUN} gcc_state_e;

   localparam logic [7:0] ADDRS  [NUM_REGS] = '{ADDR_UNIT_PD, ADDR_SER_PD, ADDR_CLK_OPT,
                                                 ADDR_TRISTATE, ADDR_CFG_LEGACY};
   localparam logic [7:0] RSTS   [NUM_REGS] = '{RST_UNIT_PD, RST_SER_PD, RST_CLK_OPT,
                                                 RST_TRISTATE, RST_CFG_LEGACY};
   localparam logic [7:0] WMASKS [NUM_REGS] = '{WM_UNIT_PD, WM_SER_PD, WM_CLK_OPT,
                                                 WM_TRISTATE, WM_CFG_LEGACY};

   gcc_state_e state_ff;
   gcc_state_e nxt_state;
   logic [7:0] regs      [NUM_REGS];
   logic [7:0] strap_msk [NUM_REGS];
   logic [7:0] strap_val [NUM_REGS];
   logic       strap_load;
   logic       access_ok;
   logic [7:0] rd_mux;

   function automatic logic hit(input logic [7:0] idx, input logic [7:0] a);
      hit = (idx == a);
   endfunction

   assign strap_load = (state_ff == GCC_ST_STRAP);

   always_comb begin
      case (state_ff)
         GCC_ST_STRAP: nxt_state = GCC_ST_RUN;
         GCC_ST_RUN:   nxt_state = GCC_ST_RUN;
         default:      nxt_state = GCC_ST_STRAP;
      endcase
   end

   assign strap_msk[0] = 8'h00;
   assign strap_val[0] = 8'h00;
   assign strap_msk[1] = 8'h00;
   assign strap_val[1] = 8'h00;
   assign strap_msk[2] = (8'h01 << B_KBC) | (8'h01 << B_FDC_DIS);
   assign strap_val[2] = ({7'h00, strap_kbc_en} << B_KBC) |
                         ({7'h00, strap_fdc_dis} << B_FDC_DIS);
   assign strap_msk[3] = 8'h00;
   assign strap_val[3] = 8'h00;
   assign strap_msk[4] = 8'h01 << B_PORTSEL;
   assign strap_val[4] = {7'h00, strap_port_sel} << B_PORTSEL;

   assign access_ok = ~regs[4][B_LOCK];

   genvar gi;
   generate
      for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
         gcc_reg8 #(
            .RST_VAL (RSTS[gi]),
            .WMASK   (WMASKS[gi])
         ) u_reg (
            .clk       (clk),
            .rstn      (rstn),
            .load      (strap_load),
            .load_mask (strap_msk[gi]),
            .load_val  (strap_val[gi]),
            .we        (cfg_wr & access_ok & hit(cfg_index, ADDRS[gi])),
            .wdata     (cfg_wdata),
            .q         (regs[gi])
         );
      end
   endgenerate

   always_comb begin
      rd_mux = 8'h00;
      for (int i = 0; i < NUM_REGS; i++) begin
         if (hit(cfg_index, ADDRS[i])) begin
            rd_mux = regs[i];
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_ff   <= GCC_ST_STRAP;
         cfg_rdata  <= 8'h00;
         cfg_rvalid <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         cfg_rdata  <= (cfg_rd & access_ok) ? rd_mux : 8'h00;
         cfg_rvalid <= cfg_rd;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control outputs
   ////////////////////////////////////////////////////////////////////////////
   logic [23:0] nxt_ctl;
   logic [23:0] ctl_ff;
   logic [7:0]  nxt_port;

   // Control outputs at reset, built from the register reset values
   localparam logic [23:0] CTL_RST = {
      RST_CFG_LEGACY[B_SB_LEG],
      RST_CFG_LEGACY[B_SA_LEG],
      RST_CFG_LEGACY[B_PR_LEG],
      RST_CFG_LEGACY[B_FD_LEG],
      RST_CFG_LEGACY[B_LOCK],
      RST_TRISTATE[B_FDC],
      RST_TRISTATE[B_PAR],
      RST_TRISTATE[B_SER_A],
      RST_TRISTATE[B_SER_B],
      RST_CLK_OPT[B_FDC_DIS],
      RST_CLK_OPT[B_KBC],
      RST_CLK_OPT[B_CPUFAN],
      RST_CLK_OPT[B_SYSFAN],
      RST_CLK_OPT[B_INPUT_CLOCK_RATE_SELECT],
      RST_SER_PD[B_SLEEP],
      RST_SER_PD[7:4],
      RST_UNIT_PD[B_FDC],
      RST_UNIT_PD[B_PAR],
      RST_UNIT_PD[B_SER_A],
      RST_UNIT_PD[B_SER_B],
      RST_UNIT_PD[B_HWMON]
   };

   assign nxt_port = regs[4][B_PORTSEL] ? CFG_PORT_HI : CFG_PORT_LO;

   assign nxt_ctl[0]    = regs[0][B_HWMON];
   assign nxt_ctl[1]    = regs[0][B_SER_B];
   assign nxt_ctl[2]    = regs[0][B_SER_A];
   assign nxt_ctl[3]    = regs[0][B_PAR];
   assign nxt_ctl[4]    = regs[0][B_FDC];
   assign nxt_ctl[8:5]  = regs[1][7:4];
   assign nxt_ctl[9]    = regs[1][B_SLEEP];
   assign nxt_ctl[10]   = regs[2][B_INPUT_CLOCK_RATE_SELECT];
   assign nxt_ctl[11]   = regs[2][B_SYSFAN];
   assign nxt_ctl[12]   = regs[2][B_CPUFAN];
   assign nxt_ctl[13]   = regs[2][B_KBC];
   assign nxt_ctl[14]   = regs[2][B_FDC_DIS];
   assign nxt_ctl[15]   = regs[3][B_SER_B];
   assign nxt_ctl[16]   = regs[3][B_SER_A];
   assign nxt_ctl[17]   = regs[3][B_PAR];
   assign nxt_ctl[18]   = regs[3][B_FDC];
   assign nxt_ctl[19]   = regs[4][B_LOCK];
   assign nxt_ctl[20]   = regs[4][B_FD_LEG] | floppy_dor_bit3;
   assign nxt_ctl[21]   = regs[4][B_PR_LEG] | parallel_control_reg_bit4;
   assign nxt_ctl[22]   = regs[4][B_SA_LEG] | serial_a_handshake_control_reg_bit3;
   assign nxt_ctl[23]   = regs[4][B_SB_LEG] | serial_b_handshake_control_reg_bit3;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctl_ff           <= CTL_RST;
         config_port_addr <= CFG_PORT_LO;
      end else begin
         ctl_ff           <= nxt_ctl;
         config_port_addr <= nxt_port;
      end
   end

   assign hardware_monitor_pwr       = ctl_ff[0];
   assign serial_b_pwr               = ctl_ff[1];
   assign serial_a_pwr               = ctl_ff[2];
   assign parallel_port_pwr          = ctl_ff[3];
   assign floppy_disk_controller_pwr = ctl_ff[4];
   assign serial_fc_pwr              = ctl_ff[8:5];
   assign immediate_chip_sleep       = ctl_ff[9];
   assign input_clock_rate_select    = ctl_ff[10];
   assign system_fan_output_pp       = ctl_ff[11];
   assign processor_fan_output_pp    = ctl_ff[12];
   assign keyboard_controller_en     = ctl_ff[13];
   assign floppy_pins_serial_f       = ctl_ff[14];
   assign serial_b_float             = ctl_ff[15];
   assign serial_a_float             = ctl_ff[16];
   assign parallel_float             = ctl_ff[17];
   assign floppy_float               = ctl_ff[18];
   assign config_lock                = ctl_ff[19];
   assign floppy_irq_en              = ctl_ff[20];
   assign parallel_irq_en            = ctl_ff[21];
   assign serial_a_irq_en            = ctl_ff[22];
   assign serial_b_irq_en            = ctl_ff[23];
endmodule

// [include/gcc_pkg.sv]
package gcc_pkg;
   // Register indices on the configuration index/data port
   localparam logic [7:0] ADDR_UNIT_PD    = 8'h22;
   localparam logic [7:0] ADDR_SER_PD     = 8'h23;
   localparam logic [7:0] ADDR_CLK_OPT    = 8'h24;
   localparam logic [7:0] ADDR_TRISTATE   = 8'h25;
   localparam logic [7:0] ADDR_CFG_LEGACY = 8'h26;
   // Reset values
   localparam logic [7:0] RST_UNIT_PD     = 8'hff;
   localparam logic [7:0] RST_SER_PD      = 8'hf0;
   localparam logic [7:0] RST_CLK_OPT     = 8'h40;
   localparam logic [7:0] RST_TRISTATE    = 8'h00;
   localparam logic [7:0] RST_CFG_LEGACY  = 8'h00;
   // Writable masks
   localparam logic [7:0] WM_UNIT_PD      = 8'h79;
   localparam logic [7:0] WM_SER_PD       = 8'hf1;
   localparam logic [7:0] WM_CLK_OPT      = 8'h5a;
   localparam logic [7:0] WM_TRISTATE     = 8'h39;
   localparam logic [7:0] WM_CFG_LEGACY   = 8'h6f;
   // Field positions
   localparam int B_HWMON    = 6;
   localparam int B_SER_B    = 5;
   localparam int B_SER_A    = 4;
   localparam int B_PAR      = 3;
   localparam int B_FDC      = 0;
   localparam int B_SLEEP    = 0;
   localparam int B_INPUT_CLOCK_RATE_SELECT   = 6;
   localparam int B_SYSFAN   = 4;
   localparam int B_CPUFAN   = 3;
   localparam int B_KBC      = 2;
   localparam int B_FDC_DIS  = 1;
   localparam int B_PORTSEL  = 6;
   localparam int B_LOCK     = 5;
   localparam int B_FD_LEG   = 3;
   localparam int B_PR_LEG   = 2;
   localparam int B_SA_LEG   = 1;
   localparam int B_SB_LEG   = 0;
   // Configuration entry key and port addresses
   localparam logic [7:0] CFG_KEY         = 8'h87;
   localparam logic [7:0] CFG_PORT_LO     = 8'h2e;
   localparam logic [7:0] CFG_PORT_HI     = 8'h4e;
   localparam int         NUM_REGS        = 5;
endpackage

// [rtl/gcc_reg8.sv]
`timescale 1ns/1ps
module gcc_reg8
   import gcc_pkg::*;
#(
   parameter logic [7:0] RST_VAL = 8'h00,
   parameter logic [7:0] WMASK   = 8'hff
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   // Strap load
   input  wire logic       load,
   input  wire logic [7:0] load_mask,
   input  wire logic [7:0] load_val,
   // Write
   input  wire logic       we,
   input  wire logic [7:0] wdata,
   // Value
   output logic      [7:0] q
);
   logic [7:0] q_ff;
   logic [7:0] nxt_q;

   // Reserved bits keep reset value, writes masked
   assign nxt_q = load ? ((q_ff & ~load_mask) | (load_val & load_mask)) :
                  we   ? ((q_ff & ~WMASK) | (wdata & WMASK)) : q_ff;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q_ff <= RST_VAL;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign q = q_ff;
endmodule

// [verification/gcc_regs_checker.sv]
`timescale 1ns/1ps
module gcc_regs_checker
   import gcc_pkg::*;
(
   // Clock and reset
   input wire logic       clk,
   input wire logic       rstn,
   // Configuration port
   input wire logic       cfg_wr,
   input wire logic       cfg_rd,
   input wire logic [7:0] cfg_index,
   input wire logic [7:0] cfg_wdata,
   input wire logic [7:0] cfg_rdata,
   input wire logic       cfg_rvalid,
   // Controls
   input wire logic       immediate_chip_sleep,
   input wire logic [7:0] config_port_addr,
   input wire logic       config_lock,
   // Legacy interrupt gating
   input wire logic       floppy_dor_bit3,
   input wire logic       parallel_control_reg_bit4,
   input wire logic       serial_a_handshake_control_reg_bit3,
   input wire logic       serial_b_handshake_control_reg_bit3,
   input wire logic       floppy_irq_en,
   input wire logic       parallel_irq_en,
   input wire logic       serial_a_irq_en,
   input wire logic       serial_b_irq_en
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////////////////////////
   sequence sleep_wr_s;
      cfg_wr && !config_lock && cfg_index == ADDR_SER_PD && cfg_wdata[B_SLEEP];
   endsequence
   sleep_set_a: assert property (sleep_wr_s |-> ##2 immediate_chip_sleep)
      else $error("chip sleep not set after write");
   lock_read_zero_a: assert property (cfg_rd && config_lock |=> cfg_rdata == 8'h00)
      else $error("locked read returned data");
   lock_sticky_a: assert property ($rose(config_lock) |=> config_lock [*8])
      else $error("lock released");
   port_addr_a: assert property (config_port_addr == CFG_PORT_LO ||
      config_port_addr == CFG_PORT_HI) else $error("bad config port");
   sequence port_wr_s;
      cfg_wr && !config_lock && cfg_index == ADDR_CFG_LEGACY;
   endsequence
   port_wr_a: assert property (port_wr_s |-> ##2 config_port_addr ==
      ($past(cfg_wdata[B_PORTSEL], 2) ? CFG_PORT_HI : CFG_PORT_LO))
      else $error("port select not applied");
   read_valid_a: assert property (cfg_rd |=> cfg_rvalid)
      else $error("read not answered");
   floppy_irq_a: assert property (floppy_dor_bit3 [*2] |-> floppy_irq_en)
      else $error("floppy irq gate ignored");
   par_irq_a: assert property ($past(parallel_control_reg_bit4) &&
      parallel_control_reg_bit4 |-> parallel_irq_en) else $error("parallel irq gate ignored");
   ser_a_irq_a: assert property (serial_a_handshake_control_reg_bit3 [*2] |-> serial_a_irq_en)
      else $error("serial a irq gate ignored");
   ser_b_irq_a: assert property (serial_b_handshake_control_reg_bit3 [*2] |-> serial_b_irq_en)
      else $error("serial b irq gate ignored");
endmodule

// [verification/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
   import gcc_pkg::*;
   logic        clk, rstn, strap_kbc_en, strap_fdc_dis, strap_port_sel;
   logic        cfg_wr, cfg_rd, cfg_rvalid;
   logic [7:0]  cfg_index, cfg_wdata, cfg_rdata;
   logic [7:0]  idx;
   logic [3:0]  gate;
   logic [31:0] obs;
   logic [7:0]  m [5];
   logic [7:0]  wm [5];
   bit          locked;
   int          failures, n_compared, k;
   ////////////////////////////////////////////////////////////////////////////////
   gcc_global_regs dut_u (.clk(clk), .rstn(rstn), .strap_kbc_en(strap_kbc_en),
      .strap_fdc_dis(strap_fdc_dis), .strap_port_sel(strap_port_sel), .cfg_wr(cfg_wr),
      .cfg_rd(cfg_rd), .cfg_index(cfg_index), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .cfg_rvalid(cfg_rvalid), .hardware_monitor_pwr(obs[31]), .serial_b_pwr(obs[30]),
      .serial_a_pwr(obs[29]), .parallel_port_pwr(obs[28]),
      .floppy_disk_controller_pwr(obs[27]), .serial_fc_pwr(obs[26:23]),
      .immediate_chip_sleep(obs[22]), .input_clock_rate_select(obs[21]),
      .system_fan_output_pp(obs[20]), .processor_fan_output_pp(obs[19]),
      .keyboard_controller_en(obs[18]), .floppy_pins_serial_f(obs[17]),
      .serial_b_float(obs[16]), .serial_a_float(obs[15]), .parallel_float(obs[14]),
      .floppy_float(obs[13]), .config_lock(obs[12]), .config_port_addr(obs[11:4]),
      .floppy_dor_bit3(gate[3]), .parallel_control_reg_bit4(gate[2]),
      .serial_a_handshake_control_reg_bit3(gate[1]),
      .serial_b_handshake_control_reg_bit3(gate[0]), .floppy_irq_en(obs[3]),
      .parallel_irq_en(obs[2]), .serial_a_irq_en(obs[1]), .serial_b_irq_en(obs[0]));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] expv();
      return {m[0][6:3], m[0][0], m[1][7:4], m[1][0], m[2][6], m[2][4:1], m[3][5:3],
              m[3][0], m[4][5], m[4][6] ? 8'h4e : 8'h2e, m[4][3:0] | gate};
   endfunction
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      $display("Compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // One request; a read returns the value held before any same-cycle write
   task automatic op(bit w, bit r, logic [7:0] i, logic [7:0] d);
      logic [7:0] old;
      int j;
      j = int'(i) - 8'h22;
      old = (locked || j < 0 || j > 4) ? 8'h00 : m[j];
      @(posedge clk);
      cfg_wr <= w;
      cfg_rd <= r;
      cfg_index <= i;
      cfg_wdata <= d;
      @(posedge clk);
      cfg_wr <= 1'b0;
      cfg_rd <= 1'b0;
      #1;
      if (r) chk({23'h0, cfg_rvalid, cfg_rdata}, {23'h0, 1'b1, old});
      if (w && !locked && j >= 0 && j <= 4) m[j] = (m[j] & ~wm[j]) | (d & wm[j]);
      locked = m[4][5];
   endtask
   task automatic outs();
      @(posedge clk);
      gate <= 4'($urandom);
      repeat (2) @(posedge clk);
      #1;
      chk(obs, expv());
   endtask
   // Reset with fresh straps; outputs checked while reset is held
   task automatic do_reset(int cycles);
      logic [2:0] sv;
      sv = 3'($urandom);
      @(posedge clk);
      rstn <= 1'b0;
      gate <= 4'h0;
      {strap_kbc_en, strap_fdc_dis, strap_port_sel} <= sv;
      m = '{RST_UNIT_PD, RST_SER_PD, RST_CLK_OPT, RST_TRISTATE, RST_CFG_LEGACY};
      locked = 1'b0;
      repeat (cycles) @(posedge clk);
      #1;
      chk(obs, expv());
      chk({23'h0, cfg_rvalid, cfg_rdata}, 32'h0);
      @(posedge clk);
      rstn <= 1'b1;
      m[2][B_KBC] = sv[2];
      m[2][B_FDC_DIS] = sv[1];
      m[4][B_PORTSEL] = sv[0];
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      final_report();
   end
   initial begin
      void'($urandom(32'ha5d9));
      {rstn, cfg_wr, cfg_rd, cfg_index, cfg_wdata, gate} = '0;
      {strap_kbc_en, strap_fdc_dis, strap_port_sel} = 3'h0;
      wm = '{WM_UNIT_PD, WM_SER_PD, WM_CLK_OPT, WM_TRISTATE, WM_CFG_LEGACY};
      do_reset(6);
      for (k = 8'h21; k <= 8'h27; k++) op(0, 1, 8'(k), 8'h00);
      outs();
      for (k = 0; k < 60; k++) begin
         idx = 8'(8'h22 + $urandom % 6);
         op(1, 1'($urandom), idx, 8'($urandom) & ((idx == 8'h26) ? 8'hdf : 8'hff));
         op(0, 1, idx, 8'h00);
         outs();
      end
      op(1, 0, 8'h26, m[4] | 8'h20);
      outs();
      op(1, 1, 8'h25, 8'hff);
      op(1, 0, 8'h26, 8'h00);
      op(0, 1, 8'h22, 8'h00);
      outs();
      do_reset(3);
      for (k = 8'h21; k <= 8'h27; k++) op(0, 1, 8'(k), 8'h00);
      outs();
      final_report();
   end
endmodule
bind gcc_global_regs gcc_regs_checker chk_u (
   .clk                                 (clk),
   .rstn                                (rstn),
   .cfg_wr                              (cfg_wr),
   .cfg_rd                              (cfg_rd),
   .cfg_index                           (cfg_index),
   .cfg_wdata                           (cfg_wdata),
   .cfg_rdata                           (cfg_rdata),
   .cfg_rvalid                          (cfg_rvalid),
   .immediate_chip_sleep                (immediate_chip_sleep),
   .config_port_addr                    (config_port_addr),
   .config_lock                         (config_lock),
   .floppy_dor_bit3                     (floppy_dor_bit3),
   .parallel_control_reg_bit4           (parallel_control_reg_bit4),
   .serial_a_handshake_control_reg_bit3 (serial_a_handshake_control_reg_bit3),
   .serial_b_handshake_control_reg_bit3 (serial_b_handshake_control_reg_bit3),
   .floppy_irq_en                       (floppy_irq_en),
   .parallel_irq_en                     (parallel_irq_en),
   .serial_a_irq_en                     (serial_a_irq_en),
   .serial_b_irq_en                     (serial_b_irq_en)
);
